/* File: hdl/synth_device.sv */
// Synthesizer, reference clock and transmit modulation control device
// Function
// - Flag low-battery when supply crosses programmed threshold
// - Low-battery event routable to any aux pin
// - Start PLL automatically once oscillator reports stable
// - External select takes reference from oscillator input pin
// - Reference output divided per field, off in sleep
// - Reference output enabled straight out of reset
// - Frequency step is reference over two^19
// - Carrier is 24-bit word at 0x06..0x08
// - Carrier commits only on low byte write
// - Two transmit PLLs, four bandwidth presets each
// - Receive mode always uses low-consumption PLL
// - RC oscillator calibrates itself after power-up
// - Host drives bits, synchronised when Gaussian
// - Bit rate is ref over divisor plus fraction/16
// - Fraction ignored in OOK modulation
// - FSK offsets ratio by step times deviation
// - Software keeps deviation within limits
// - OOK switches amplifier, ramps bias when shaped
// - FSK shaping picks Gaussian BT 0.5 or 1
// - Bit clock pulses once per needed bit
// - Software restarts transmitter after shaping change
// - Output select picks pin and power base
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module synth_device (
  input logic sys_clk,
  input logic resetn,
  synth_link_if.device link,
  input logic [7:0] supply_level,
  input logic osc_ready,
  output logic pll_start,
  output logic pll_running,
  output logic pll_low_noise,
  output logic [1:0] pll_bandwidth,
  output logic ref_from_ext,
  output logic [23:0] synth_word,
  output logic [3:0] amp_bias,
  output logic low_power_rf_pin,
  output logic boost_amp_pin,
  output logic [5:0] power_dbm,
  output logic rc_cal_busy
);
  logic [7:0] mode_q, mode_d, thr_q, thr_d, pwr_q, pwr_d;
  logic [15:0] br_q, br_d, frs_q, frs_d;
  logic [3:0] brf_q, brf_d;
  logic [13:0] dev_q, dev_d;
  logic [23:0] frf_q, frf_d;
  logic [1:0] shp_q, shp_d;
  logic [2:0] pll_q, pll_d, map2_q, map2_d;
  logic [5:0] map_q, map_d;
  logic ext_q, ext_d;
  logic [6:0] wa;
  logic [7:0] wd;
  synth_pkg::op_mode_t op;

  assign wa = link.reg_addr;
  assign wd = link.reg_wdata;
  assign op = synth_pkg::op_mode_t'(mode_q[2:0]);

  // Register writes from the host
  always_comb begin
    mode_d = mode_q;
    br_d = br_q;
    brf_d = brf_q;
    dev_d = dev_q;
    frs_d = frs_q;
    frf_d = frf_q;
    pwr_d = pwr_q;
    shp_d = shp_q;
    thr_d = thr_q;
    pll_d = pll_q;
    map_d = map_q;
    map2_d = map2_q;
    ext_d = ext_q;
    if (link.reg_wr) begin
      case (wa)
        synth_pkg::A_MODE: mode_d = wd;
        synth_pkg::A_BR_HI: br_d[15:8] = wd;
        synth_pkg::A_BR_LO: br_d[7:0] = wd;
        synth_pkg::A_BR_FRAC: brf_d = wd[3:0];
        synth_pkg::A_DEV_HI: dev_d[13:8] = wd[5:0];
        synth_pkg::A_DEV_LO: dev_d[7:0] = wd;
        synth_pkg::A_FRF_HI: frs_d[15:8] = wd;
        synth_pkg::A_FRF_MID: frs_d[7:0] = wd;
        synth_pkg::A_FRF_LO: frf_d = {frs_q, wd};
        synth_pkg::A_PWR: pwr_d = wd;
        synth_pkg::A_SHAPE: shp_d = wd[1:0];
        synth_pkg::A_LOWBAT: thr_d = wd;
        synth_pkg::A_PLL: pll_d = wd[2:0];
        synth_pkg::A_MAP: map_d = wd[5:0];
        synth_pkg::A_MAP2: map2_d = wd[2:0];
        synth_pkg::A_EXTREF: ext_d = wd[synth_pkg::EXTREF_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= synth_pkg::MODE_RST;
      br_q <= 16'h0;
      brf_q <= 4'h0;
      dev_q <= 14'h0;
      frs_q <= 16'h0;
      frf_q <= 24'h0;
      pwr_q <= 8'h0;
      shp_q <= 2'h0;
      thr_q <= 8'h0;
      pll_q <= 3'h0;
      map_q <= 6'h0;
      map2_q <= synth_pkg::REFERENCE_CLOCK_OUTPUT_RST;
      ext_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      br_q <= br_d;
      brf_q <= brf_d;
      dev_q <= dev_d;
      frs_q <= frs_d;
      frf_q <= frf_d;
      pwr_q <= pwr_d;
      shp_q <= shp_d;
      thr_q <= thr_d;
      pll_q <= pll_d;
      map_q <= map_d;
      map2_q <= map2_d;
      ext_q <= ext_d;
    end
  end

  // Map a bit to a signed unit for the Gaussian taps
  function automatic logic signed [4:0] pm(input logic b);
    pm = b ? 5'sh01 : -5'sh01;
  endfunction

  logic in_tx, ook, cont, gauss, ref_tick, bit_tick, cur_bit;
  logic pll_run_q, pll_run_d, go_q, go_d, rc_busy_q, rc_busy_d;
  logic rc_done_q, rc_done_d, below_q, below_d, lb_q, lb_d, pin_q, pin_d;
  logic clk_out_q, clk_out_d, bclk_q, bclk_d, lp_q, lp_d, bst_q, bst_d;
  logic pln_q, pln_d;
  logic [7:0] rc_cnt_q, rc_cnt_d, rdata_q, rdata_d;
  logic [5:0] div_q, div_d, dbm_q, dbm_d;
  logic [2:0] hist_q, hist_d;
  logic [3:0] ramp_q, ramp_d;
  logic [23:0] syn_q, syn_d;
  logic signed [4:0] s;
  logic signed [19:0] prod, off;

  assign in_tx = (op == synth_pkg::M_TX);
  assign ook = mode_q[synth_pkg::MODE_OOK_BIT];
  assign cont = mode_q[synth_pkg::MODE_CONT_BIT];
  assign gauss = !ook && (shp_q != synth_pkg::SH_NONE);
  // Pin is synchronous to sys_clk; its rising edge is the reference tick
  assign ref_tick = ext_q ? (link.oscillator_input_pin && !pin_q) : 1'b1;
  // Unshaped continuous bits pass straight through
  assign cur_bit = (cont && !gauss) ? link.tx_data : hist_q[0];

  bit_rate_gen u_rate (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(in_tx),
    .ref_tick(ref_tick),
    .divisor(br_q),
    .frac(ook ? 4'h0 : brf_q),
    .bit_tick(bit_tick)
  );

  // Core sequencing, reference output and modulation state
  always_comb begin
    pll_run_d = pll_run_q;
    go_d = 1'b0;
    rc_busy_d = rc_busy_q;
    rc_done_d = rc_done_q;
    rc_cnt_d = rc_cnt_q;
    lb_d = lb_q;
    rdata_d = rdata_q;
    pin_d = link.oscillator_input_pin;
    below_d = supply_level < thr_q;
    div_d = ref_tick ? div_q + 6'h1 : div_q;
    // Sleep stops the output; codes past the last divider switch it off
    clk_out_d = (op != synth_pkg::M_SLEEP) && (map2_q <= synth_pkg::REFERENCE_CLOCK_OUTPUT_LAST)
      && div_q[map2_q];
    if (op == synth_pkg::M_SLEEP) begin
      pll_run_d = 1'b0;
    end else if (osc_ready && !pll_run_q) begin
      pll_run_d = 1'b1;
      go_d = 1'b1;
    end
    // Busy resets high, so calibration runs after reset
    if (rc_busy_q) begin
      rc_cnt_d = rc_cnt_q + 8'h1;
      if (rc_cnt_q == synth_pkg::RC_CYC - 8'h1) begin
        rc_busy_d = 1'b0;
        rc_done_d = 1'b1;
      end
    end
    if (link.reg_wr && wa == synth_pkg::A_OSC && wd[synth_pkg::RC_START_BIT]) begin
      rc_busy_d = 1'b1;
      rc_done_d = 1'b0;
      rc_cnt_d = 8'h0;
    end
    // Reading status clears the flag; a new crossing wins over the read
    if (link.reg_rd && wa == synth_pkg::A_STAT) begin
      lb_d = 1'b0;
    end
    if (below_d && !below_q) begin
      lb_d = 1'b1;
    end
    // Leaving transmit clears the filter history so it restarts clean
    hist_d = hist_q;
    if (!in_tx) begin
      hist_d = 3'h0;
    end else if (bit_tick) begin
      hist_d = {hist_q[1:0], link.tx_data};
    end
    bclk_d = in_tx && cont && gauss && bit_tick;
    case (shp_q)
      synth_pkg::SH_BT1: s = (pm(hist_q[0]) + pm(hist_q[1])) <<< 1;
      synth_pkg::SH_BT05: s = pm(hist_q[0]) + (pm(hist_q[1]) <<< 1)
        + pm(hist_q[2]);
      default: s = pm(cur_bit) <<< 2;
    endcase
    prod = $signed({6'h0, dev_q}) * $signed({{15{s[4]}}, s});
    off = prod >>> 2;
    syn_d = (in_tx && !ook) ? frf_q + {{4{off[19]}}, off} : frf_q;
    // OOK keys the amplifier; shaping walks the bias one step a cycle
    ramp_d = 4'h0;
    if (in_tx && (!ook || cur_bit)) begin
      ramp_d = synth_pkg::RAMP_MAX;
    end
    if (ook && shp_q != synth_pkg::SH_NONE) begin
      if (ramp_d > ramp_q) begin
        ramp_d = ramp_q + 4'h1;
      end else if (ramp_d < ramp_q) begin
        ramp_d = ramp_q - 4'h1;
      end
    end
    lp_d = in_tx && !pwr_q[synth_pkg::PWR_SEL_BIT];
    bst_d = in_tx && pwr_q[synth_pkg::PWR_SEL_BIT];
    dbm_d = {2'h0, pwr_q[3:0]} + (!pwr_q[synth_pkg::PWR_SEL_BIT] ?
      synth_pkg::DBM_LP : pwr_q[synth_pkg::PWR_HP_BIT] ?
      synth_pkg::DBM_HP : synth_pkg::DBM_BOOST);
    pln_d = in_tx && pll_q[synth_pkg::PLL_LN_BIT];
    if (link.reg_rd) begin
      case (wa)
        synth_pkg::A_MODE: rdata_d = mode_q;
        synth_pkg::A_BR_HI: rdata_d = br_q[15:8];
        synth_pkg::A_BR_LO: rdata_d = br_q[7:0];
        synth_pkg::A_BR_FRAC: rdata_d = {4'h0, brf_q};
        synth_pkg::A_DEV_HI: rdata_d = {2'h0, dev_q[13:8]};
        synth_pkg::A_DEV_LO: rdata_d = dev_q[7:0];
        synth_pkg::A_FRF_HI: rdata_d = frs_q[15:8];
        synth_pkg::A_FRF_MID: rdata_d = frs_q[7:0];
        synth_pkg::A_FRF_LO: rdata_d = frf_q[7:0];
        synth_pkg::A_PWR: rdata_d = pwr_q;
        synth_pkg::A_SHAPE: rdata_d = {6'h0, shp_q};
        synth_pkg::A_OSC: rdata_d = {7'h0, rc_done_q};
        synth_pkg::A_LOWBAT: rdata_d = thr_q;
        synth_pkg::A_PLL: rdata_d = {5'h0, pll_q};
        synth_pkg::A_MAP: rdata_d = {2'h0, map_q};
        synth_pkg::A_MAP2: rdata_d = {5'h0, map2_q};
        synth_pkg::A_EXTREF: rdata_d = {3'h0, ext_q, 4'h0};
        synth_pkg::A_STAT: rdata_d = {3'h0, rc_done_q, rc_busy_q, lb_q,
          below_q, pll_run_q};
        default: rdata_d = 8'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pll_run_q <= 1'b0;
      go_q <= 1'b0;
      rc_busy_q <= 1'b1;
      rc_done_q <= 1'b0;
      rc_cnt_q <= 8'h0;
      below_q <= 1'b0;
      lb_q <= 1'b0;
      pin_q <= 1'b0;
      div_q <= 6'h0;
      clk_out_q <= 1'b0;
      hist_q <= 3'h0;
      bclk_q <= 1'b0;
      ramp_q <= 4'h0;
      syn_q <= 24'h0;
      lp_q <= 1'b0;
      bst_q <= 1'b0;
      dbm_q <= 6'h0;
      pln_q <= 1'b0;
      rdata_q <= 8'h0;
    end else begin
      pll_run_q <= pll_run_d;
      go_q <= go_d;
      rc_busy_q <= rc_busy_d;
      rc_done_q <= rc_done_d;
      rc_cnt_q <= rc_cnt_d;
      below_q <= below_d;
      lb_q <= lb_d;
      pin_q <= pin_d;
      div_q <= div_d;
      clk_out_q <= clk_out_d;
      hist_q <= hist_d;
      bclk_q <= bclk_d;
      ramp_q <= ramp_d;
      syn_q <= syn_d;
      lp_q <= lp_d;
      bst_q <= bst_d;
      dbm_q <= dbm_d;
      pln_q <= pln_d;
      rdata_q <= rdata_d;
    end
  end

  // Aux pins: mapped bit carries the low-battery flag, else default use
  logic [5:0] aux_dflt;
  assign aux_dflt = {clk_out_q, 3'h0, bclk_q, 1'b0};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_aux
      assign link.aux_io[gi] = map_q[gi] ? lb_q : aux_dflt[gi];
    end
  endgenerate

  assign link.tx_bit_clock = bclk_q;
  assign link.reg_rdata = rdata_q;
  assign pll_start = go_q;
  assign pll_running = pll_run_q;
  assign pll_low_noise = pln_q;
  assign pll_bandwidth = pll_q[1:0];
  assign ref_from_ext = ext_q;
  assign synth_word = syn_q;
  assign amp_bias = ramp_q;
  assign low_power_rf_pin = lp_q;
  assign boost_amp_pin = bst_q;
  assign power_dbm = dbm_q;
  assign rc_cal_busy = rc_busy_q;
endmodule : synth_device

/* File: hdl/synth_pkg.sv */
// Shared constants for the synthesizer and modulation control link
package synth_pkg;
  // Clock and timing
  localparam int CLK_NS = 40;
  localparam int RC_CAL_NS = 2000;
  localparam logic [7:0] RC_CYC = 8'((RC_CAL_NS + CLK_NS - 1) / CLK_NS);
  localparam int EXT_HALF_CYC = 2;

  // Device register byte addresses on the link
  localparam logic [6:0] A_MODE = 7'h01;
  localparam logic [6:0] A_BR_HI = 7'h02;
  localparam logic [6:0] A_BR_LO = 7'h03;
  localparam logic [6:0] A_DEV_HI = 7'h04;
  localparam logic [6:0] A_DEV_LO = 7'h05;
  localparam logic [6:0] A_FRF_HI = 7'h06;
  localparam logic [6:0] A_FRF_MID = 7'h07;
  localparam logic [6:0] A_FRF_LO = 7'h08;
  localparam logic [6:0] A_PWR = 7'h09;
  localparam logic [6:0] A_SHAPE = 7'h0a;
  localparam logic [6:0] A_OSC = 7'h0b;
  localparam logic [6:0] A_LOWBAT = 7'h0c;
  localparam logic [6:0] A_PLL = 7'h0d;
  localparam logic [6:0] A_MAP = 7'h0e;
  localparam logic [6:0] A_MAP2 = 7'h0f;
  localparam logic [6:0] A_EXTREF = 7'h10;
  localparam logic [6:0] A_BR_FRAC = 7'h11;
  localparam logic [6:0] A_STAT = 7'h12;

  // Field positions and reset values
  localparam int MODE_OOK_BIT = 3;
  localparam int MODE_CONT_BIT = 4;
  localparam int PWR_SEL_BIT = 7;
  localparam int PWR_HP_BIT = 4;
  localparam int PLL_LN_BIT = 2;
  localparam int RC_START_BIT = 3;
  localparam int EXTREF_BIT = 4;
  localparam logic [2:0] REFERENCE_CLOCK_OUTPUT_RST = 3'h0;
  localparam logic [2:0] REFERENCE_CLOCK_OUTPUT_LAST = 3'h5;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [3:0] RAMP_MAX = 4'hf;
  localparam logic [5:0] DBM_LP = 6'h3f;
  localparam logic [5:0] DBM_BOOST = 6'h02;
  localparam logic [5:0] DBM_HP = 6'h05;

  typedef enum logic [2:0] {
    M_SLEEP = 3'b000, M_STBY = 3'b001, M_FS = 3'b010,
    M_TX = 3'b011, M_RX = 3'b100
  } op_mode_t;
  typedef enum logic [1:0] {
    SH_NONE = 2'b00, SH_BT1 = 2'b01, SH_BT05 = 2'b10
  } shaping_t;

  // Deviation limits in synthesizer steps of ref/2^19
  localparam longint REF_HZ = 32000000;
  localparam longint STEP_DEN = 524288;
  localparam logic [13:0] DEV_MIN = 14'((600 * STEP_DEN + REF_HZ - 1) / REF_HZ);
  localparam logic [13:0] DEV_MAX = 14'((200000 * STEP_DEN) / REF_HZ);
  localparam logic [15:0] DEV_SUM = 16'((250000 * STEP_DEN) / REF_HZ);
  localparam logic [31:0] HALF_BR = 32'(STEP_DEN / 2);

  // Host APB register byte addresses and fields
  localparam logic [7:0] H_CTRL = 8'h00;
  localparam logic [7:0] H_CMD = 8'h04;
  localparam logic [7:0] H_STAT = 8'h08;
  localparam logic [7:0] H_TX = 8'h0c;
  localparam int CMD_RD_BIT = 16;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_TX_BIT = 1;
endpackage : synth_pkg

/* File: hdl/synth_link_if.sv */
// Link between host controller and synthesizer control device
`timescale 1ns/1ps
interface synth_link_if (
  input logic sys_clk
);
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic oscillator_input_pin;
  logic tx_data;
  logic tx_bit_clock;
  logic [5:0] aux_io;

  modport device (
    input reg_addr, reg_wdata, reg_wr, reg_rd, oscillator_input_pin,
    input tx_data,
    output reg_rdata, tx_bit_clock, aux_io
  );
  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd, oscillator_input_pin,
    output tx_data,
    input reg_rdata, tx_bit_clock, aux_io
  );
endinterface : synth_link_if

/* File: hdl/bit_rate_gen.sv */
// Fractional bit-rate divider clocked by reference ticks
`timescale 1ns/1ps
module bit_rate_gen (
  input logic sys_clk,
  input logic resetn,
  input logic run,
  input logic ref_tick,
  input logic [15:0] divisor,
  input logic [3:0] frac,
  output logic bit_tick
);
  logic [15:0] cnt_q, cnt_d;
  logic [3:0] acc_q, acc_d;
  logic ext_q, ext_d;
  logic tick_q, tick_d;
  logic last;

  // Carry of the fraction stretches one period by a tick
  always_comb begin
    cnt_d = cnt_q;
    acc_d = acc_q;
    ext_d = ext_q;
    tick_d = 1'b0;
    last = ({1'b0, cnt_q} + 17'h1) >= ({1'b0, divisor} + {16'h0, ext_q});
    if (!run) begin
      cnt_d = 16'h0;
      acc_d = 4'h0;
      ext_d = 1'b0;
    end else if (ref_tick) begin
      if (last) begin
        cnt_d = 16'h0;
        tick_d = 1'b1;
        {ext_d, acc_d} = {1'b0, acc_q} + {1'b0, frac};
      end else begin
        cnt_d = cnt_q + 16'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 16'h0;
      acc_q <= 4'h0;
      ext_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      ext_q <= ext_d;
      tick_q <= tick_d;
    end
  end

  assign bit_tick = tick_q;
endmodule : bit_rate_gen

/* File: hdl/synth_host.sv */
// Host controller: APB command registers driving the device link
`timescale 1ns/1ps
module synth_host (
  input logic sys_clk,
  input logic resetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  synth_link_if.host link
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_SEND = 3'b001, S_READ = 3'b010,
    S_STBY = 3'b011, S_MODE = 3'b100
  } hstate_t;

  hstate_t st_q, st_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [6:0] addr_q, addr_d;
  logic [7:0] data_q, data_d, rd_q, rd_d, mode_q, mode_d, txb_q, txb_d;
  logic [7:0] dh_q, dh_d, dl_q, dl_d, bh_q, bh_d, bl_q, bl_d;
  logic wr_q, wr_d, rdq, rdd, err_q, err_d, rst_q, rst_d, txd_q, txd_d;
  logic ck_q, ck_d, ok;
  logic [3:0] ckc_q, ckc_d;
  logic [31:0] prd_q, prd_d;
  logic [13:0] dev;
  logic [15:0] div;
  logic wacc, mapped;

  assign wacc = psel && penable && pwrite;
  assign mapped = paddr == synth_pkg::H_CTRL || paddr == synth_pkg::H_CMD ||
    paddr == synth_pkg::H_STAT || paddr == synth_pkg::H_TX;

  always_comb begin
    st_d = st_q; ctrl_d = ctrl_q; addr_d = addr_q; data_d = data_q;
    rd_d = rd_q; mode_d = mode_q; txb_d = txb_q; txd_d = txd_q;
    dh_d = dh_q; dl_d = dl_q; bh_d = bh_q; bl_d = bl_q;
    wr_d = 1'b0; rdd = 1'b0; err_d = err_q; rst_d = rst_q;
    prd_d = prd_q; ck_d = ck_q; ckc_d = ckc_q + 4'h1;
    // Deviation limits checked before the link
    dev = {dh_q[5:0], dl_q};
    div = {bh_q, bl_q};
    if (pwdata[6:0] == synth_pkg::A_DEV_LO) dev = {dh_q[5:0], pwdata[15:8]};
    if (pwdata[6:0] == synth_pkg::A_BR_LO) div = {bh_q, pwdata[15:8]};
    ok = dev >= synth_pkg::DEV_MIN && dev <= synth_pkg::DEV_MAX &&
      32'(synth_pkg::DEV_SUM - {2'h0, dev}) * 32'(div) >= synth_pkg::HALF_BR;
    if (psel && !penable) begin
      case (paddr)
        synth_pkg::H_CTRL: prd_d = {30'h0, ctrl_q};
        synth_pkg::H_STAT: prd_d = {16'h0, rd_q, 5'h0, rst_q, err_q,
          st_q != S_IDLE};
        synth_pkg::H_TX: prd_d = {24'h0, txb_q};
        default: prd_d = 32'h0;
      endcase
    end
    if (wacc && paddr == synth_pkg::H_CTRL) ctrl_d = pwdata[1:0];
    if (wacc && paddr == synth_pkg::H_TX) begin
      txb_d = pwdata[7:0];
      txd_d = pwdata[7];
    end else if (link.tx_bit_clock && ctrl_q[synth_pkg::CTRL_TX_BIT]) begin
      txb_d = {txb_q[6:0], 1'b0};
      txd_d = txb_q[6];
    end
    // Fixed-rate external reference while enabled
    if (!ctrl_q[synth_pkg::CTRL_EXT_BIT]) begin
      ck_d = 1'b0;
      ckc_d = 4'h0;
    end else if (ckc_q == 4'(synth_pkg::EXT_HALF_CYC - 1)) begin
      ck_d = !ck_q;
      ckc_d = 4'h0;
    end
    case (st_q)
      S_IDLE: begin
        if (wacc && paddr == synth_pkg::H_CMD) begin
          err_d = 1'b0;
          addr_d = pwdata[6:0];
          data_d = pwdata[15:8];
          if (pwdata[synth_pkg::CMD_RD_BIT]) begin
            rdd = 1'b1;
            st_d = S_READ;
          end else if ((pwdata[6:0] == synth_pkg::A_DEV_LO ||
              pwdata[6:0] == synth_pkg::A_BR_LO) && !ok) begin
            err_d = 1'b1;
          end else begin
            wr_d = 1'b1;
            st_d = S_SEND;
            case (pwdata[6:0])
              synth_pkg::A_DEV_HI: dh_d = pwdata[15:8];
              synth_pkg::A_DEV_LO: dl_d = pwdata[15:8];
              synth_pkg::A_BR_HI: bh_d = pwdata[15:8];
              synth_pkg::A_BR_LO: bl_d = pwdata[15:8];
              synth_pkg::A_MODE: mode_d = pwdata[15:8];
              synth_pkg::A_SHAPE: rst_d = 1'b1;
              default: ;
            endcase
          end
        end
      end
      S_SEND: st_d = rst_q ? S_STBY : S_IDLE;
      S_READ: begin
        rd_d = link.reg_rdata;
        if (!rdq) st_d = S_IDLE;
      end
      S_STBY: begin
        // Standby, a gap, then the old mode to recalibrate
        addr_d = synth_pkg::A_MODE;
        data_d = {mode_q[7:3], synth_pkg::M_STBY};
        wr_d = 1'b1;
        st_d = S_MODE;
      end
      S_MODE: begin
        data_d = mode_q;
        wr_d = !wr_q;
        rst_d = wr_q;
        st_d = wr_q ? S_MODE : S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
    if (wacc && paddr == synth_pkg::H_CMD && st_q != S_IDLE) err_d = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= S_IDLE; ctrl_q <= 2'h0; addr_q <= 7'h0; data_q <= 8'h0;
      rd_q <= 8'h0; mode_q <= synth_pkg::MODE_RST; txb_q <= 8'h0;
      txd_q <= 1'b0; dh_q <= 8'h0; dl_q <= 8'h0; bh_q <= 8'h0;
      bl_q <= 8'h0; wr_q <= 1'b0; rdq <= 1'b0; err_q <= 1'b0;
      rst_q <= 1'b0; prd_q <= 32'h0; ck_q <= 1'b0; ckc_q <= 4'h0;
    end else begin
      st_q <= st_d; ctrl_q <= ctrl_d; addr_q <= addr_d; data_q <= data_d;
      rd_q <= rd_d; mode_q <= mode_d; txb_q <= txb_d; txd_q <= txd_d;
      dh_q <= dh_d; dl_q <= dl_d; bh_q <= bh_d; bl_q <= bl_d;
      wr_q <= wr_d; rdq <= rdd; err_q <= err_d; rst_q <= rst_d;
      prd_q <= prd_d; ck_q <= ck_d; ckc_q <= ckc_d;
    end
  end

  assign prdata = prd_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign link.reg_addr = addr_q;
  assign link.reg_wdata = data_q;
  assign link.reg_wr = wr_q;
  assign link.reg_rd = rdq;
  assign link.oscillator_input_pin = ck_q;
  assign link.tx_data = txd_q;
endmodule : synth_host

/* File: sim/synth_link_assertions.sv */
// Link-side checker for the synth host and device ends
`timescale 1ns/1ps
module synth_link_assertions (
  input logic sys_clk,
  input logic resetn,
  input logic [6:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic tx_bit_clock,
  input logic [5:0] aux_io
);
  logic [7:0] mode_q, mode_d, map_q, map_d, div_q, div_d;
  logic ext_q, ext_d;
  // Shadows of link writes to steering registers
  always_comb begin
    mode_d = reg_wr && reg_addr == synth_pkg::A_MODE ? reg_wdata : mode_q;
    map_d = reg_wr && reg_addr == synth_pkg::A_MAP ? reg_wdata : map_q;
    div_d = reg_wr && reg_addr == synth_pkg::A_MAP2 ? reg_wdata : div_q;
    ext_d = reg_wr && reg_addr == synth_pkg::A_EXTREF ?
      reg_wdata[synth_pkg::EXTREF_BIT] : ext_q;
  end
  // Shadow registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= synth_pkg::MODE_RST;
      map_q <= 8'h00;
      div_q <= 8'h00;
      ext_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      map_q <= map_d;
      div_q <= div_d;
      ext_q <= ext_d;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Four cycles of margin absorb the pin mux flops
  sequence s_sleep; (mode_q[2:0] == 3'h0 && !map_q[5]) [*4]; endsequence
  sequence s_no_tx; (mode_q[2:0] != 3'h3) [*4]; endsequence
  sequence s_ref;
    (mode_q[2:0] != 3'h0 && div_q[2:0] == 3'h0 && !map_q[5] && !ext_q) [*4];
  endsequence
  strobe_excl_a: assert property (!(reg_wr && reg_rd))
    else $error("read and write strobes together");
  strobe_gap_a: assert property ((reg_wr || reg_rd) |=> !(reg_wr || reg_rd))
    else $error("link strobes too close");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read byte moved without a read");
  bitclk_pulse_a: assert property (tx_bit_clock |=> !tx_bit_clock)
    else $error("bit clock wider than one cycle");
  bitclk_tx_a: assert property (s_no_tx |-> !tx_bit_clock)
    else $error("bit clock outside transmit");
  bitclk_pin_a: assert property (tx_bit_clock && !map_q[1] |-> ##[0:1] aux_io[1])
    else $error("bit clock missing on its pin");
  reference_clock_output_sleep_a: assert property (s_sleep |-> !aux_io[5])
    else $error("reference output alive in sleep");
  reference_clock_output_run_a: assert property (s_ref |-> aux_io[5] != $past(aux_io[5]))
    else $error("reference output not toggling");
endmodule : synth_link_assertions

/* File: sim/synth_and_tx_modulation_control_tb_top.sv */
// Bench driving APB commands through host to device
`timescale 1ns/1ps
module synth_and_tx_modulation_control_tb_top;
  logic sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, supply_level = 8'hff;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, osc_ready = 0, err_bit, pll_running, pll_low_noise;
  logic ref_from_ext, rc_cal_busy, low_power_rf_pin, boost_amp_pin;
  logic [1:0] pll_bandwidth;
  logic [23:0] synth_word;
  logic [5:0] power_dbm;
  logic [7:0] pw[3] = '{8'h00, 8'h8f, 8'h93};
  logic [5:0] dbm[3] = '{6'h3f, 6'h11, 6'h08};
  int errors = 0, check_count = 0, cycles = 0, n;
  always #20 sys_clk = ~sys_clk;
  synth_link_if link (.sys_clk);
  synth_host u_synth_host (.sys_clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link));
  synth_device u_synth_device (.sys_clk, .resetn, .link(link),
    .supply_level, .osc_ready, .pll_start(), .pll_running, .pll_low_noise,
    .pll_bandwidth, .ref_from_ext, .synth_word, .amp_bias(),
    .low_power_rf_pin, .boost_amp_pin, .power_dbm, .rc_cal_busy);
  synth_link_assertions u_synth_link_assertions (.sys_clk, .resetn,
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata),
    .tx_bit_clock(link.tx_bit_clock), .aux_io(link.aux_io));
  task automatic print_verdict;
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // Cycle count by NBA for settled reads
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      errors++;
      print_verdict;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err_bit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  // Command then poll busy; a read leaves its byte in rd[15:8]
  task automatic dev(input logic w, input logic [6:0] a, input logic [7:0] d);
    apb(1, synth_pkg::H_CMD, {15'h0, !w, d, 1'b0, a});
    do apb(0, synth_pkg::H_STAT, 0); while (rd[0] !== 1'b0);
  endtask : dev
  task automatic pulse;
    do @(posedge sys_clk); while (!(link.tx_bit_clock ||
      u_synth_device.ook && u_synth_device.bit_tick));
  endtask : pulse
  // Two bit periods; a half fraction adds one tick
  task automatic bits(output int k);
    int t;
    pulse;
    t = cycles;
    pulse;
    pulse;
    k = cycles - t;
  endtask : bits
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    check(rc_cal_busy, 1);
    repeat (60) @(posedge sys_clk);
    check({rc_cal_busy, pll_running}, 0);
    osc_ready <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(pll_running, 1);
    dev(1, synth_pkg::A_FRF_HI, 8'h12);
    dev(1, synth_pkg::A_FRF_MID, 8'h34);
    check(synth_word, 0);
    dev(1, synth_pkg::A_FRF_LO, 8'h56);
    check(synth_word, 24'h123456);
    dev(0, synth_pkg::A_FRF_HI, 0);
    check(rd[15:8], 8'h12);
    dev(1, synth_pkg::A_OSC, 8'h08);
    check(rc_cal_busy, 1);
    repeat (60) @(posedge sys_clk);
    dev(0, synth_pkg::A_OSC, 0);
    check({rc_cal_busy, rd[8]}, 1);
    dev(1, synth_pkg::A_EXTREF, 8'h10);
    apb(1, synth_pkg::H_CTRL, 1);
    check(ref_from_ext, 1);
    dev(1, synth_pkg::A_EXTREF, 0);
    apb(1, synth_pkg::H_CTRL, 0);
    dev(1, synth_pkg::A_LOWBAT, 8'h80);
    dev(1, synth_pkg::A_MAP, 8'h01);
    supply_level <= 8'h10;
    repeat (4) @(posedge sys_clk);
    check(link.aux_io[0], 1);
    dev(0, synth_pkg::A_STAT, 0);
    check(rd[10:9], 2'h3);
    dev(1, synth_pkg::A_PLL, 8'h06);
    for (int i = 0; i < 3; i++) begin
      dev(1, synth_pkg::A_PWR, pw[i]);
      dev(1, synth_pkg::A_MODE, 8'h03);
      check(power_dbm, dbm[i]);
      check({low_power_rf_pin, boost_amp_pin}, {!pw[i][7], pw[i][7]});
    end
    check({pll_low_noise, pll_bandwidth}, 3'h6);
    dev(1, synth_pkg::A_MODE, 8'h04);
    check(pll_low_noise, 0);
    dev(1, synth_pkg::A_BR_HI, 8'h01);
    dev(1, synth_pkg::A_DEV_HI, 8'h01);
    dev(1, synth_pkg::A_BR_LO, 8'h40);
    dev(1, synth_pkg::A_BR_FRAC, 8'h08);
    dev(1, synth_pkg::A_SHAPE, 8'h01);
    for (int i = 0; i < 2; i++) begin
      dev(1, synth_pkg::A_MODE, i ? 8'h0b : 8'h13);
      bits(n);
      check(n, i ? 640 : 641);
    end
    dev(1, synth_pkg::A_MODE, 8'h00);
    repeat (8) @(posedge sys_clk);
    check(link.aux_io[5], 0);
    dev(1, synth_pkg::A_MODE, 8'h01);
    apb(0, 8'h40, 0);
    check({rd[30:0], err_bit}, 1);
    print_verdict;
  end
endmodule : synth_and_tx_modulation_control_tb_top
